// ===== design/cop_port_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Coprocessor side of the host bus
module cop_port_dev (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Host bus
   cop_bus_if.dev bus,
   // Strap pin; low selects slow timing, open reads high
   input wire logic cycle_timing_strap_n,
   // User side: instruction written by host
   output logic [31:0] instr_data,
   output logic instr_valid,
   // User side: result to return on reads
   input wire logic [31:0] result_data
);
   import cop_bus_pkg::*;
   // Timing overview of one cycle, counted in clocks of clk:
   // - strobe, direction and ready pins pass two flip-flops before decoding,
   //   so a strobe is acted on two clocks after the host drove it
   // - a start latches the write word at once; data that moves
   //   later, while the host holds its ready back, is not used
   // - the wait counter then runs down to zero and the ack follows
   // - the ack stands until the synchronised host ready is low
   // The two synchroniser stages cost latency on every cycle; this
   // was accepted so the port can sit behind pins that are not
   // timed against clk, at the price of slower acks.
   // Strap high (or open, which reads high): ready is driven at all
   // times out of reset, high when idle. Strap low: ready is floated between
   // acks so that other slaves may share the line.

   // Cycle phases seen from the device side
   typedef enum {
      S_IDLE, // Waiting for a strobe or a pipelined start
      S_WAIT, // Counting wait states before the ack
      S_ACK // Ack driven, waiting for host ready
   } st_e;

   // Whole module state, one register for all of it
   typedef struct packed {
      // Sequencing
      st_e st;              // Cycle phase
      logic [1:0] cnt;      // Wait states still to go
      logic wr;             // Direction of the cycle in progress
      // Pin synchronisers
      logic [1:0] ss;       // Strap sync
      logic [2:0] as_s1;    // First sync stage: strobe, wr, ready
      logic [2:0] as_s2;    // Second sync stage
      logic pipe;           // Strobe seen during previous cycle
      // Ready pin
      logic rdy_n;          // Ready level, low acknowledges
      logic rdy_oe;         // Ready driver enable
      // Read data pins
      logic [31:0] rd;      // Word shown to the host
      logic rd_oe;          // Data driver enable
      // User side
      logic [31:0] ins;     // Last instruction word written
      logic ins_v;          // One clock pulse per write
   } st_s;
   st_s r;                  // Registered state
   st_s n;                  // Next state
   // Decoded views of the second synchroniser stage
   logic ads_n;             // Strobe, active low
   logic wr_s;              // Direction, high for a write
   logic hrdy_n;            // Host ready, active low
   logic strap_low;         // Slow timing selected

   // Synchronised views only; first stage feeds only the second.
   // Reading the first stage anywhere else would let a metastable
   // level reach the decoder.
   always_comb
   begin
      ads_n = r.as_s2[2];
      wr_s = r.as_s2[1];
      hrdy_n = r.as_s2[0];
      // An open strap pin reads high, so it selects fast timing
      strap_low = ~r.ss[1];
   end

   // Next-state logic. Every field starts from its held value, so
   // a branch only names what it changes; pulses and the ready
   // pin are then given their idle values before the case.
   always_comb
   begin
      n = r;
      n.as_s1 = {bus.host_addr_strobe_n, bus.host_wr, bus.host_ready_n};
      n.as_s2 = r.as_s1;
      n.ss = {r.ss[0], cycle_timing_strap_n};
      n.ins_v = 1'b0;
      // Ready driven only in strap-high mode between acks
      n.rdy_oe = ~strap_low;
      n.rdy_n = 1'b1;
      case (r.st)
         S_IDLE:
         begin
            // Start when strobe seen and bus idle or pipelined.
            // A strobe that came while the previous cycle was still
            // open is remembered in pipe, so that start is not lost
            // even though the strobe is long gone by now.
            if (!ads_n || r.pipe)
            begin
               n.wr = wr_s;
               n.pipe = 1'b0;
               if (wr_s)
               begin
                  // Latch at fixed point, later changes ignored
                  n.ins = bus.wdata;
                  n.ins_v = 1'b1;
                  // Pipelined writes take the short path always
                  n.cnt = (strap_low && !r.pipe) ? WR_WAIT_SLOW
                                                 : WR_WAIT_FAST;
               end
               else
               begin
                  // Read: drivers come on now with a dummy word, the
                  // result itself is only loaded with the ack, so the
                  // host must not trust the bus before ready.
                  n.cnt = RD_WAIT;
                  n.rd_oe = 1'b1;
                  n.rd = 32'h0000_0000;
               end
               n.st = S_WAIT;
            end
         end
         S_WAIT:
         begin
            // A new strobe here marks the next cycle as pipelined
            if (!ads_n)
            begin
               n.pipe = 1'b1;
            end
            // Count the wait states down, then acknowledge
            if (r.cnt != 2'h0)
            begin
               n.cnt = r.cnt - 2'h1;
            end
            else
            begin
               // Ack and, on a read, load the result in one step
               n.rdy_n = 1'b0;
               n.rdy_oe = 1'b1;
               if (!r.wr)
                  n.rd = result_data;
               n.st = S_ACK;
            end
         end
         S_ACK:
         begin
            // The host may already be addressing its next cycle
            if (!ads_n)
            begin
               n.pipe = 1'b1;
            end
            if (!hrdy_n)
            begin
               // Host has ended the cycle: release ready and data.
               // In strap-low mode the default above floats ready.
               n.rd_oe = 1'b0;
               n.st = S_IDLE;
            end
            else
            begin
               // Hold ack and data until host ready
               n.rdy_n = 1'b0;
               n.rdy_oe = 1'b1;
            end
         end
         default:
         begin
            // Unreachable phase: go back to idle
            n.st = S_IDLE;
         end
      endcase
   end

   // State register; reset is synchronous to host clock.
   // An asynchronous reset would need its own synchroniser here,
   // the host already delivers one aligned to clk.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // Clear everything, then give the pins their idle levels:
         // strobe and host ready read high, strap reads high
         r <= '0;
         r.st <= S_IDLE;
         r.rdy_n <= 1'b1;
         r.as_s1 <= 3'h5;
         r.as_s2 <= 3'h5;
         r.ss <= 2'h3;
         r.rd <= RESULT_RST;
      end
      else
      begin
         r <= n;
      end
   end

   // Every output comes straight from the state register
   assign bus.dev_rdy_o_n = r.rdy_n;
   assign bus.dev_rdy_oe = r.rdy_oe;
   assign bus.rdata = r.rd;
   assign bus.rdata_oe = r.rd_oe;
   // User side: the word stands until the next write, the valid
   // pulse lasts one clock per write cycle
   assign instr_data = r.ins;
   assign instr_valid = r.ins_v;
endmodule : cop_port_dev
`default_nettype wire

// ===== design/cop_bus_pkg.sv
package cop_bus_pkg;
   // Data bus width
   localparam int unsigned DATA_W = 32;
   // Wait states before the ack, write with strap high, or pipelined write
   localparam logic [1:0] WR_WAIT_FAST = 2'h0;
   // Write wait with strap low, non-pipelined
   localparam logic [1:0] WR_WAIT_SLOW = 2'h1;
   // Read waits; same for both strap values
   localparam logic [1:0] RD_WAIT = 2'h1;
   // Result value after reset
   localparam logic [31:0] RESULT_RST = 32'h0000_0000;
endpackage : cop_bus_pkg

// ===== design/cop_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
// Local bus between host and coprocessor port
interface cop_bus_if;
   // Host driven cycle signals
   logic host_addr_strobe_n;
   logic host_wr;
   logic host_ready_n;
   logic [31:0] wdata;
   // Device ready pin, two signals plus resolved level
   logic dev_rdy_o_n;
   logic dev_rdy_oe;
   logic dev_rdy_n;
   // Device read data with enable
   logic [31:0] rdata;
   logic rdata_oe;
   // Idle line floats high through a pull-up
   assign dev_rdy_n = dev_rdy_oe ? dev_rdy_o_n : 1'b1;
   modport dev (input host_addr_strobe_n, input host_wr,
                input host_ready_n, input wdata,
                output dev_rdy_o_n, output dev_rdy_oe,
                output rdata, output rdata_oe);
   modport host (output host_addr_strobe_n, output host_wr,
                 output host_ready_n, output wdata,
                 input dev_rdy_n, input rdata, input rdata_oe);
endinterface : cop_bus_if
`default_nettype wire

// ===== design/cop_port_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host side: issues one write or read per request
module cop_port_host (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Host bus
   cop_bus_if.host bus,
   // User request
   input wire logic req,
   input wire logic req_wr,
   input wire logic [31:0] req_data,
   output logic busy,
   // Completion
   output logic done,
   output logic [31:0] rd_data
);
   import cop_bus_pkg::*;
   typedef enum {H_IDLE, H_ADDR, H_WAIT, H_END} hst_e;
   typedef struct packed {
      hst_e st;
      logic ads_n;
      logic wr;
      logic hrdy_n;
      logic [31:0] wd;
      logic [31:0] rd;
      logic done;
      logic [1:0] d1;    // Ready pin sync stages one and two
      logic d2;          // Ready pin sync stage three
      logic busy;        // Cycle in progress
   } h_s;
   h_s r, n;
   // Next-state logic
   always_comb
   begin
      n = r;
      n.d1 = {r.d1[0], bus.dev_rdy_n};
      n.d2 = r.d1[1];
      n.done = 1'b0;
      case (r.st)
         H_IDLE:
            if (req)
            begin
               // One write or read cycle per request, as req_wr selects
               n.ads_n = 1'b0;
               n.wr = req_wr;
               n.wd = req_data;
               n.st = H_ADDR;
            end
         H_ADDR:
         begin
            n.ads_n = 1'b1;
            n.st = H_WAIT;
         end
         H_WAIT:
            // Data trusted only at device ready
            if (!r.d2)
            begin
               if (!r.wr)
                  n.rd = bus.rdata;
               n.hrdy_n = 1'b0;
               n.st = H_END;
            end
         H_END:
         begin
            n.hrdy_n = 1'b1;
            n.done = 1'b1;
            n.st = H_IDLE;
         end
         default:
            n.st = H_IDLE;
      endcase
      // Busy kept in a register so the output comes from a flip-flop
      n.busy = (n.st != H_IDLE);
   end
   // State register
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         r <= '0;
         r.st <= H_IDLE;
         r.ads_n <= 1'b1;
         r.hrdy_n <= 1'b1;
         r.d1 <= 2'h3;
         r.d2 <= 1'b1;
      end
      else
         r <= n;
   end
   assign bus.host_addr_strobe_n = r.ads_n;
   assign bus.host_wr = r.wr;
   assign bus.host_ready_n = r.hrdy_n;
   assign bus.wdata = r.wd;
   assign busy = r.busy;
   assign done = r.done;
   assign rd_data = r.rd;
endmodule : cop_port_host
`default_nettype wire

// ===== verif/cop_bus_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the bus that joins the two ends
module cop_bus_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Strap level
   input wire logic cycle_timing_strap_n,
   // Bus signals
   input wire logic host_addr_strobe_n,
   input wire logic host_wr,
   input wire logic host_ready_n,
   input wire logic dev_rdy_o_n,
   input wire logic dev_rdy_oe,
   input wire logic dev_rdy_n,
   input wire logic [31:0] rdata,
   input wire logic rdata_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Start seen as the strobe falls
   sequence rd_go;
      $fell(host_addr_strobe_n) && !host_wr;
   endsequence
   a_read_wait: assert property (rd_go |-> dev_rdy_n [*4])
      else $error("read acked too early");
   a_write_slow: assert property (
      $fell(host_addr_strobe_n) && host_wr && !cycle_timing_strap_n
      |-> dev_rdy_n [*4])
      else $error("slow write too short");
   // Strobe is seen two clocks late, the ack follows two clocks later
   a_write_fast: assert property (
      $fell(host_addr_strobe_n) && host_wr && cycle_timing_strap_n
      |-> ##4 !dev_rdy_n)
      else $error("fast write ack off time");
   a_ack_bound: assert property ($fell(host_addr_strobe_n)
      |-> ##[1:8] !dev_rdy_n) else $error("no ack");
   a_read_drive: assert property (rd_go |-> ##[1:4] rdata_oe)
      else $error("read drivers not enabled");
   // Host ready reaches the device through two flip-flops
   a_read_hold: assert property (
      rdata_oe && !dev_rdy_n && $past(host_ready_n, 2)
      |=> rdata_oe) else $error("read data dropped");
   a_ack_release: assert property (!dev_rdy_n && !host_ready_n
      |-> ##[1:3] dev_rdy_n) else $error("ack not released");
   // The strap passes two flip-flops before the enable follows it
   a_ready_float: assert property (
      !cycle_timing_strap_n && !$past(cycle_timing_strap_n, 3)
      && dev_rdy_oe |-> !dev_rdy_o_n)
      else $error("ready driven between acks");
   // Main scenarios reached
   c_read: cover property (rd_go);
   c_slow: cover property (host_wr && !cycle_timing_strap_n && !dev_rdy_n);
   c_fast: cover property (host_wr && cycle_timing_strap_n && !dev_rdy_n);
endmodule : cop_bus_monitor
`default_nettype wire

// ===== verif/coprocessor_host_bus_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
// Writes and reads in all strap settings, checked against a queue model
module coprocessor_host_bus_port_bench;
   import cop_bus_pkg::*;
   logic clk = 0, srst = 1, strap = 1, req = 0, req_wr = 0;
   logic [31:0] req_data = 0, result_data = RESULT_RST;
   logic [31:0] instr_data, rd_data, seed = 32'h0000_7a0f;
   logic instr_valid, busy, done;
   int miscompares = 0, n_compared = 0;
   logic [31:0] got[$]; // Instructions seen by the device
   cop_bus_if bus ();
   cop_port_dev u_cop_port_dev (.clk(clk), .srst(srst), .bus(bus),
      .cycle_timing_strap_n(strap), .instr_data(instr_data),
      .instr_valid(instr_valid), .result_data(result_data));
   cop_port_host u_cop_port_host (.clk(clk), .srst(srst), .bus(bus),
      .req(req), .req_wr(req_wr), .req_data(req_data), .busy(busy),
      .done(done), .rd_data(rd_data));
   cop_bus_monitor u_cop_bus_monitor (.clk(clk), .srst(srst),
      .cycle_timing_strap_n(strap), .host_addr_strobe_n(bus.host_addr_strobe_n),
      .host_wr(bus.host_wr), .host_ready_n(bus.host_ready_n),
      .dev_rdy_o_n(bus.dev_rdy_o_n), .dev_rdy_oe(bus.dev_rdy_oe),
      .dev_rdy_n(bus.dev_rdy_n), .rdata(bus.rdata), .rdata_oe(bus.rdata_oe));
   initial forever #12.5 clk = ~clk;
   // Xorshift source for data words
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // Collect every instruction the device hands over
   // Sampled on the falling edge, away from the edge that launches it
   always @(negedge clk)
      if (instr_valid === 1'b1)
         got.push_back(instr_data);
   // One host cycle; data changed right after launch must not leak in
   task automatic op(input logic wr, input logic sp);
      logic [31:0] d;
      int n;
      d = xs();
      @(posedge clk);
      #2;
      strap = sp;
      result_data = d;
      req = 1;
      req_wr = wr;
      req_data = d;
      @(posedge clk);
      #2;
      req = 0;
      req_data = xs();
      check(32'(busy), 32'h0000_0001);
      n = 0;
      while (done !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check(32'(n < 40), 32'h0000_0001);
      check(32'(busy), 32'h0000_0000);
      if (!wr)
         check(rd_data, d);
      // The result was taken with the ack; moving it now must not
      // change what the host already holds
      #1;
      result_data = ~d;
      repeat (4) @(posedge clk);
      #1;
      if (!wr)
         check(rd_data, d);
      if (wr)
      begin
         check(32'(got.size()), 32'h0000_0001);
         if (got.size() > 0)
            check(got.pop_front(), d);
      end
   endtask : op
   // Main sequence: every mix of direction and strap, repeatedly
   initial
   begin
      repeat (6) @(posedge clk);
      #2;
      srst = 0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 32; i++)
         op(i[0], i[1]);
      conclude();
   end
   // Hang guard
   initial
   begin
      repeat (5000) @(posedge clk);
      miscompares++;
      conclude();
   end
endmodule : coprocessor_host_bus_port_bench
`default_nettype wire
